// *** fic_pkg.sv ***
// package: constants of the fast input counter unit
package fic_pkg;
  localparam int FIC_NIN = 8;
  localparam int FIC_NCH = 4;
  localparam int FIC_CW = 24;
  localparam int FIC_DW = 16;
  localparam int FIC_FAST_LO = 4;
  localparam logic [7:0] FIC_EL_DIFF = 8'h08;
  localparam logic [7:0] FIC_EL_TB = 8'h09;
  localparam logic [7:0] FIC_EL_CFG = 8'h14;
  localparam logic [7:0] FIC_EL_CNT0 = 8'h19;
  localparam logic [7:0] FIC_EL_POL = 8'h1D;
  localparam logic [7:0] FIC_EL_EDGE = 8'h1E;
  localparam logic [7:0] FIC_EL_FILT0 = 8'h2D;
  localparam logic [7:0] FIC_POL_RST = 8'hFF;
  localparam logic [7:0] FIC_EDGE_RST = 8'h00;
  localparam logic [7:0] FIC_TB_RST = 8'h0A;
  localparam logic [7:0] FIC_FILT_RST = 8'h00;
  localparam int FIC_CLK_NS = 10;
  localparam int FIC_TB_UNIT_NS = 10000000;
  localparam int FIC_TICK_CYCLES = FIC_TB_UNIT_NS / FIC_CLK_NS;
  localparam int FIC_TICKW = 20;
  localparam logic [FIC_CW-1:0] FIC_ONE = 24'h000001;
  localparam logic [7:0] FIC_TB_ONE = 8'h01;
  typedef enum logic [1:0] {FIC_TB_RUN = 2'b01, FIC_TB_SAMPLE = 2'b10} fic_tb_t;
endpackage : fic_pkg

// *** fic_chan_if.sv ***
// interface: one single-channel counter's controls and reading
`timescale 1ns/100ps
`default_nettype none
interface fic_chan_if;
  import fic_pkg::*;
  logic sig;
  logic pol;
  logic lvl;
  logic en;
  logic load;
  logic [FIC_CW-1:0] ldval;
  logic [FIC_CW-1:0] count;
  modport ctrl (output sig, output pol, output lvl, output en, output load, output ldval, input count);
  modport chan (input sig, input pol, input lvl, input en, input load, input ldval, output count);
endinterface : fic_chan_if
`default_nettype wire

// *** fic_cnt_chan.sv ***
// module: one up-only event counter with edge or level qualification
`timescale 1ns/100ps
`default_nettype none
module fic_cnt_chan
  import fic_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  fic_chan_if.chan ch
);
  logic prev_ff;
  logic nxt_prev;
  logic [FIC_CW-1:0] cnt_ff;
  logic [FIC_CW-1:0] nxt_cnt;
  logic hit;

  always_comb begin
    if (ch.lvl) begin
      hit = (ch.sig == ch.pol);
    end else if (ch.pol) begin
      hit = ch.sig & ~prev_ff;
    end else begin
      hit = ~ch.sig & prev_ff;
    end
    nxt_prev = ch.sig;
    if (ch.load) begin
      nxt_cnt = ch.ldval;
    end else if (ch.en && hit) begin
      nxt_cnt = cnt_ff + FIC_ONE;
    end else begin
      nxt_cnt = cnt_ff;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      prev_ff <= 1'b0;
      cnt_ff <= '0;
    end else begin
      prev_ff <= nxt_prev;
      cnt_ff <= nxt_cnt;
    end
  end

  assign ch.count = cnt_ff;
endmodule : fic_cnt_chan
`default_nettype wire

// *** fic_unit.sv ***
// module: fast input counter unit, top level
// Function
// - four independent single-channel counters on fast inputs five to eight
// - inputs five and six feed the dual counter; their single counters then stop
// - counter-configured inputs no longer push state changes to the host
// - single counters only ever increment
// - four counter readings read and written as consecutive array elements
// - readings of inputs five and eight also at two direct registers
// - writing a reading loads the counter, counting continues from it
// - edge evaluation after reset, qualified by polarity and edge/state elements
// - with stretching active the counter sees the stretched signal
// - manual stretch enable or disable stops or resumes incrementing
// - dual counter enabled by a status/controller configuration bit
// - dual reading shares the array element of the input five reading
// - array element holds the input five counter reading difference
// - array element holds the time base of that difference
// - four array elements hold the software filter interval per fast input
// - polarity one selects rising edge or high level, zero falling or low
// - edge/state one qualifies on level, zero on edge
`timescale 1ns/100ps
`default_nettype none
module fic_unit
  import fic_pkg::*;
#(
  parameter int TICK_CYCLES = FIC_TICK_CYCLES
)
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [FIC_NIN-1:0] pin_in,
  input wire logic dual_en,
  input wire logic idx_wr,
  input wire logic [7:0] idx_wdata,
  input wire logic dat_wr,
  input wire logic [FIC_CW-1:0] wdata,
  input wire logic cnt5_wr,
  input wire logic cnt8_wr,
  input wire logic stretch_on_wr,
  input wire logic stretch_off_wr,
  input wire logic [FIC_NIN-1:0] stretch_mask,
  output logic [7:0] idx_q,
  output logic [FIC_CW-1:0] dat_rdata,
  output logic [FIC_CW-1:0] cnt5_q,
  output logic [FIC_CW-1:0] cnt8_q,
  output logic [FIC_NIN-1:0] stretch_q,
  output logic [FIC_NIN-1:0] push_q,
  output logic [FIC_NIN-1:0] state_q
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] idx_ff, nxt_idx;
  logic [7:0] cfg_ff, nxt_cfg;
  logic [7:0] pol_ff, nxt_pol;
  logic [7:0] edge_ff, nxt_edge;
  logic [7:0] tb_ff, nxt_tb;
  logic [7:0] filt_ff [FIC_NCH], nxt_filt [FIC_NCH];
  logic [FIC_NIN-1:0] man_ff, nxt_man;
  logic [FIC_NIN-1:0] held_ff, nxt_held;
  logic [FIC_NIN-1:0] prev_in_ff, nxt_prev_in;
  logic [FIC_NIN-1:0] push_ff, nxt_push;
  logic [FIC_CW-1:0] rdata_ff, nxt_rdata;
  logic [FIC_CW-1:0] dual_ff, nxt_dual;
  logic [1:0] qprev_ff, nxt_qprev;
  logic [FIC_CW-1:0] last_ff, nxt_last;
  logic [FIC_DW-1:0] diff_ff, nxt_diff;
  logic [FIC_TICKW-1:0] tick_ff, nxt_tick;
  logic [7:0] tbc_ff, nxt_tbc;
  fic_tb_t tbst_ff, nxt_tbst;
  logic [FIC_NIN-1:0] eff_in;
  logic [FIC_CW-1:0] rd5;
  logic [FIC_CW-1:0] cnt [FIC_NCH];
  logic arr_wr;

  fic_chan_if chif [FIC_NCH] ();

  assign arr_wr = dat_wr;
  assign rd5 = dual_en ? dual_ff : cnt[0];

  // manual stretch freezes the counter input at its level when enabled
  always_comb begin
    for (int i = 0; i < FIC_NIN; i++) begin
      eff_in[i] = man_ff[i] ? held_ff[i] : pin_in[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < FIC_NCH; g++) begin : g_ch
      localparam logic [7:0] EL = FIC_EL_CNT0 + 8'(g);
      assign chif[g].sig = eff_in[FIC_FAST_LO+g];
      assign chif[g].pol = pol_ff[FIC_FAST_LO+g];
      assign chif[g].lvl = edge_ff[FIC_FAST_LO+g];
      assign chif[g].en = ~man_ff[FIC_FAST_LO+g] & ~(dual_en && (g < 2));
      assign chif[g].load = (arr_wr && idx_ff == EL && !(dual_en && g == 0))
                            || (cnt5_wr && !dual_en && g == 0)
                            || (cnt8_wr && g == FIC_NCH - 1);
      assign chif[g].ldval = wdata;
      assign cnt[g] = chif[g].count;
      fic_cnt_chan u_chan (
        .mclk (mclk),
        .nrst (nrst),
        .ch (chif[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // configuration elements, index register and read path
  always_comb begin
    nxt_idx = idx_wr ? idx_wdata : idx_ff;
    nxt_cfg = cfg_ff;
    nxt_pol = pol_ff;
    nxt_edge = edge_ff;
    nxt_tb = tb_ff;
    for (int i = 0; i < FIC_NCH; i++) begin
      nxt_filt[i] = filt_ff[i];
    end
    if (arr_wr) begin
      case (idx_ff)
        FIC_EL_CFG: nxt_cfg = wdata[7:0];
        FIC_EL_POL: nxt_pol = wdata[7:0];
        FIC_EL_EDGE: nxt_edge = wdata[7:0];
        // zero is outside the time base range, so it is refused
        FIC_EL_TB: nxt_tb = (wdata[7:0] != 8'h00) ? wdata[7:0] : tb_ff;
        default: begin
          for (int i = 0; i < FIC_NCH; i++) begin
            if (idx_ff == FIC_EL_FILT0 + 8'(i)) begin
              nxt_filt[i] = wdata[7:0];
            end
          end
        end
      endcase
    end
    nxt_rdata = '0;
    case (idx_ff)
      FIC_EL_DIFF: nxt_rdata = FIC_CW'({{(FIC_CW-FIC_DW){diff_ff[FIC_DW-1]}}, diff_ff});
      FIC_EL_TB: nxt_rdata = FIC_CW'(tb_ff);
      FIC_EL_CFG: nxt_rdata = FIC_CW'(cfg_ff);
      FIC_EL_POL: nxt_rdata = FIC_CW'(pol_ff);
      FIC_EL_EDGE: nxt_rdata = FIC_CW'(edge_ff);
      FIC_EL_CNT0: nxt_rdata = rd5;
      default: begin
        for (int i = 1; i < FIC_NCH; i++) begin
          if (idx_ff == FIC_EL_CNT0 + 8'(i)) begin
            nxt_rdata = cnt[i];
          end
        end
        for (int i = 0; i < FIC_NCH; i++) begin
          if (idx_ff == FIC_EL_FILT0 + 8'(i)) begin
            nxt_rdata = FIC_CW'(filt_ff[i]);
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      idx_ff <= 8'h00;
      cfg_ff <= 8'h00;
      pol_ff <= FIC_POL_RST;
      edge_ff <= FIC_EDGE_RST;
      tb_ff <= FIC_TB_RST;
      for (int i = 0; i < FIC_NCH; i++) begin
        filt_ff[i] <= FIC_FILT_RST;
      end
      rdata_ff <= '0;
    end else begin
      idx_ff <= nxt_idx;
      cfg_ff <= nxt_cfg;
      pol_ff <= nxt_pol;
      edge_ff <= nxt_edge;
      tb_ff <= nxt_tb;
      for (int i = 0; i < FIC_NCH; i++) begin
        filt_ff[i] <= nxt_filt[i];
      end
      rdata_ff <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // manual stretch, change push and dual counter
  always_comb begin
    nxt_man = man_ff;
    if (stretch_on_wr) begin
      nxt_man = nxt_man | stretch_mask;
    end
    if (stretch_off_wr) begin
      nxt_man = nxt_man & ~stretch_mask;
    end
    for (int i = 0; i < FIC_NIN; i++) begin
      nxt_held[i] = man_ff[i] ? held_ff[i] : pin_in[i];
    end
    nxt_prev_in = pin_in;
    // counter inputs are left to the host's own polling
    nxt_push = (pin_in ^ prev_in_ff) & ~cfg_ff;
    nxt_qprev = {pin_in[FIC_FAST_LO+1], pin_in[FIC_FAST_LO]};
    nxt_dual = dual_ff;
    if ((arr_wr && idx_ff == FIC_EL_CNT0 && dual_en) || (cnt5_wr && dual_en)) begin
      nxt_dual = wdata;
    end else if (dual_en && (nxt_qprev != qprev_ff)) begin
      // x4 decoding; a double step is taken as noise and ignored
      if (^(nxt_qprev ^ qprev_ff)) begin
        if (qprev_ff[0] ^ nxt_qprev[1]) begin
          nxt_dual = dual_ff - FIC_ONE;
        end else begin
          nxt_dual = dual_ff + FIC_ONE;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      man_ff <= '0;
      held_ff <= '0;
      prev_in_ff <= '0;
      push_ff <= '0;
      qprev_ff <= 2'h0;
      dual_ff <= '0;
    end else begin
      man_ff <= nxt_man;
      held_ff <= nxt_held;
      prev_in_ff <= nxt_prev_in;
      push_ff <= nxt_push;
      qprev_ff <= nxt_qprev;
      dual_ff <= nxt_dual;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // time base and reading difference for input five
  always_comb begin
    nxt_tick = tick_ff;
    nxt_tbc = tbc_ff;
    nxt_tbst = tbst_ff;
    nxt_last = last_ff;
    nxt_diff = diff_ff;
    case (tbst_ff)
      FIC_TB_RUN: begin
        if (tick_ff == FIC_TICKW'(TICK_CYCLES - 1)) begin
          nxt_tick = '0;
          if (tbc_ff >= tb_ff - FIC_TB_ONE) begin
            nxt_tbc = 8'h00;
            nxt_tbst = FIC_TB_SAMPLE;
          end else begin
            nxt_tbc = tbc_ff + FIC_TB_ONE;
          end
        end else begin
          nxt_tick = tick_ff + FIC_TICKW'(1);
        end
      end
      FIC_TB_SAMPLE: begin
        nxt_diff = FIC_DW'(rd5 - last_ff);
        nxt_last = rd5;
        nxt_tick = FIC_TICKW'(1);
        nxt_tbst = FIC_TB_RUN;
      end
      default: nxt_tbst = FIC_TB_RUN;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      tick_ff <= '0;
      tbc_ff <= 8'h00;
      tbst_ff <= FIC_TB_RUN;
      last_ff <= '0;
      diff_ff <= '0;
    end else begin
      tick_ff <= nxt_tick;
      tbc_ff <= nxt_tbc;
      tbst_ff <= nxt_tbst;
      last_ff <= nxt_last;
      diff_ff <= nxt_diff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs: direct-register readings are taken one cycle late from counters
  logic [FIC_CW-1:0] c5_ff, c8_ff;
  logic [FIC_NIN-1:0] st_ff;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      c5_ff <= '0;
      c8_ff <= '0;
      st_ff <= '0;
    end else begin
      c5_ff <= rd5;
      c8_ff <= cnt[FIC_NCH-1];
      st_ff <= pin_in;
    end
  end

  assign idx_q = idx_ff;
  assign dat_rdata = rdata_ff;
  assign cnt5_q = c5_ff;
  assign cnt8_q = c8_ff;
  assign stretch_q = man_ff;
  assign push_q = push_ff;
  assign state_q = st_ff;
endmodule : fic_unit
`default_nettype wire

// *** fic_unit_assertions.sv ***
// checker: port-level properties of the fast input counter unit
`timescale 1ns/100ps
`default_nettype none
module fic_unit_assertions
  import fic_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic idx_wr,
  input wire logic [7:0] idx_wdata,
  input wire logic dat_wr,
  input wire logic [FIC_CW-1:0] wdata,
  input wire logic cnt5_wr,
  input wire logic cnt8_wr,
  input wire logic stretch_on_wr,
  input wire logic stretch_off_wr,
  input wire logic [FIC_NIN-1:0] stretch_mask,
  input wire logic [7:0] idx_q,
  input wire logic [FIC_CW-1:0] cnt5_q,
  input wire logic [FIC_CW-1:0] cnt8_q,
  input wire logic [FIC_NIN-1:0] stretch_q,
  input wire logic [FIC_NIN-1:0] push_q,
  input wire logic [FIC_NIN-1:0] state_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // three frozen cycles without a load, so no increment can still be in flight
  sequence s_frozen;
    (stretch_q[7] && !cnt8_wr && !dat_wr) [*3];
  endsequence
  a_idx_load: assert property (idx_wr |=> idx_q == $past(idx_wdata))
    else $error("index register not loaded");
  a_cnt8_load: assert property (cnt8_wr |=> ##1 cnt8_q == $past(wdata, 2))
    else $error("input 8 reading not preset");
  a_cnt5_load: assert property (cnt5_wr |=> ##1 cnt5_q == $past(wdata, 2))
    else $error("input 5 reading not preset");
  // array writes can preset the input 8 reading as well, so they are excluded too
  a_cnt8_up_only: assert property ($past(nrst, 2) && $past(nrst, 3) && !$past(cnt8_wr, 2) && !$past(dat_wr, 2) |->
    cnt8_q == $past(cnt8_q) || cnt8_q == $past(cnt8_q) + FIC_ONE)
    else $error("input 8 reading moved other than by one up");
  a_push_cause: assert property ($past(nrst, 2) |->
    (push_q & ~(state_q ^ $past(state_q))) == 8'h00)
    else $error("push without an input change");
  a_stretch_set: assert property (stretch_on_wr && !stretch_off_wr |=>
    (stretch_q & $past(stretch_mask)) == $past(stretch_mask))
    else $error("stretch bits not set");
  a_stretch_clr: assert property (stretch_off_wr |=> (stretch_q & $past(stretch_mask)) == 8'h00)
    else $error("stretch bits not cleared");
  a_stretch_hold: assert property (s_frozen |=> $stable(cnt8_q))
    else $error("counter moved while stretched");
endmodule : fic_unit_assertions
////////////////////////////////////////
bind fic_unit fic_unit_assertions chk (.mclk(mclk), .nrst(nrst), .idx_wr(idx_wr), .idx_wdata(idx_wdata),
  .dat_wr(dat_wr), .wdata(wdata), .cnt5_wr(cnt5_wr), .cnt8_wr(cnt8_wr), .stretch_on_wr(stretch_on_wr),
  .stretch_off_wr(stretch_off_wr), .stretch_mask(stretch_mask), .idx_q(idx_q), .cnt5_q(cnt5_q),
  .cnt8_q(cnt8_q), .stretch_q(stretch_q), .push_q(push_q), .state_q(state_q));
`default_nettype wire

// *** fic_host.sv ***
// host model: drives the register side of the fast input counter unit
`timescale 1ns/100ps
`default_nettype none
module fic_host
  import fic_pkg::*;
(
  input wire logic mclk,
  input wire logic [FIC_CW-1:0] dat_rdata,
  output logic dual_en = 1'b0,
  output logic idx_wr = 1'b0,
  output logic [7:0] idx_wdata = 8'h00,
  output logic dat_wr = 1'b0,
  output logic [FIC_CW-1:0] wdata = 24'h000000,
  output logic cnt5_wr = 1'b0,
  output logic cnt8_wr = 1'b0,
  output logic stretch_on_wr = 1'b0,
  output logic stretch_off_wr = 1'b0,
  output logic [FIC_NIN-1:0] stretch_mask = 8'h00
);
  // released index and write data lines show the inverse, so a stale value never passes
  task automatic sel(input logic [7:0] i);
    @(posedge mclk) #1 idx_wr = 1'b1;
    idx_wdata = i;
    @(posedge mclk) #1 idx_wr = 1'b0;
    idx_wdata = ~i;
  endtask : sel
  task automatic wr(input logic [7:0] i, input logic [FIC_CW-1:0] v);
    sel(i);
    dat_wr = 1'b1;
    wdata = v;
    @(posedge mclk) #1 dat_wr = 1'b0;
    wdata = ~v;
  endtask : wr
  task automatic rd(input logic [7:0] i, output logic [FIC_CW-1:0] v);
    sel(i);
    @(posedge mclk) #1 v = dat_rdata;
  endtask : rd
  task automatic dwr(input logic hi, input logic [FIC_CW-1:0] v);
    @(posedge mclk) #1 cnt8_wr = hi;
    cnt5_wr = !hi;
    wdata = v;
    @(posedge mclk) #1 cnt8_wr = 1'b0;
    cnt5_wr = 1'b0;
    wdata = ~v;
  endtask : dwr
  task automatic str(input logic on, input logic [FIC_NIN-1:0] m);
    @(posedge mclk) #1 stretch_on_wr = on;
    stretch_off_wr = !on;
    stretch_mask = m;
    @(posedge mclk) #1 stretch_on_wr = 1'b0;
    stretch_off_wr = 1'b0;
  endtask : str
endmodule : fic_host
`default_nettype wire

// *** tb.sv ***
// testbench: directed register and pin sequences for the fast input counter unit
`timescale 1ns/100ps
`default_nettype none
module tb;
  import fic_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [FIC_NIN-1:0] pin_in = 8'h00;
  logic dual_en, idx_wr, dat_wr, cnt5_wr, cnt8_wr, stretch_on_wr, stretch_off_wr;
  logic [7:0] idx_wdata, idx_q;
  logic [FIC_CW-1:0] wdata, dat_rdata, cnt5_q, cnt8_q, v, b;
  logic [FIC_NIN-1:0] stretch_mask, stretch_q, push_q, state_q, push_seen;
  int mismatches = 0;
  int checks = 0;
  int cyc = 0;
  always #5 mclk = ~mclk;
  fic_host h (.mclk(mclk), .dat_rdata(dat_rdata), .dual_en(dual_en), .idx_wr(idx_wr), .idx_wdata(idx_wdata),
    .dat_wr(dat_wr), .wdata(wdata), .cnt5_wr(cnt5_wr), .cnt8_wr(cnt8_wr), .stretch_on_wr(stretch_on_wr),
    .stretch_off_wr(stretch_off_wr), .stretch_mask(stretch_mask));
  fic_unit #(.TICK_CYCLES(10)) uut (.mclk(mclk), .nrst(nrst), .pin_in(pin_in), .dual_en(dual_en),
    .idx_wr(idx_wr), .idx_wdata(idx_wdata), .dat_wr(dat_wr), .wdata(wdata), .cnt5_wr(cnt5_wr),
    .cnt8_wr(cnt8_wr), .stretch_on_wr(stretch_on_wr), .stretch_off_wr(stretch_off_wr),
    .stretch_mask(stretch_mask), .idx_q(idx_q), .dat_rdata(dat_rdata), .cnt5_q(cnt5_q), .cnt8_q(cnt8_q),
    .stretch_q(stretch_q), .push_q(push_q), .state_q(state_q));
  ////////////////////////////////////////
  always @(posedge mclk) begin
    cyc++;
    push_seen <= nrst ? (push_seen | push_q) : 8'h00;
    if (cyc == 6000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic chk(input logic [FIC_CW-1:0] s, input logic [FIC_CW-1:0] e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic pls(input int k, input int n);
    repeat (n) begin
      @(posedge mclk) #1 pin_in[k] = 1'b1;
      repeat (3) @(posedge mclk);
      #1 pin_in[k] = 1'b0;
      repeat (4) @(posedge mclk);
      #1;
    end
  endtask : pls
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (16) @(posedge mclk);
    #1 nrst = 1'b1;
    h.rd(FIC_EL_POL, v);
    chk(v, 24'h0000FF);
    h.rd(FIC_EL_EDGE, v);
    chk(v, 24'h000000);
    h.wr(FIC_EL_CFG, 24'h000080);
    pls(7, 3);
    pls(0, 1);
    chk({16'h0000, push_seen}, 24'h000001);
    chk(cnt8_q, 24'h000003);
    h.dwr(1'b1, 24'h123450);
    pls(7, 3);
    chk(cnt8_q, 24'h123453);
    h.wr(FIC_EL_POL, 24'h00007F);
    pls(7, 2);
    chk(cnt8_q, 24'h123455);
    // polarity first, so level mode never starts on a matching low input
    h.wr(FIC_EL_POL, 24'h0000FF);
    h.wr(FIC_EL_EDGE, 24'h000080);
    b = cnt8_q;
    pls(7, 1);
    chk(cnt8_q, b + 24'h000003);
    h.wr(FIC_EL_EDGE, 24'h000000);
    h.str(1'b1, 8'h80);
    chk({16'h0000, stretch_q}, 24'h000080);
    b = cnt8_q;
    pls(7, 2);
    chk(cnt8_q, b);
    h.str(1'b0, 8'h80);
    pls(7, 1);
    chk(cnt8_q, b + FIC_ONE);
    for (int i = 0; i < 4; i++) begin
      h.wr(FIC_EL_CNT0 + 8'(i), 24'(24'h010101 * (i + 1)));
      h.rd(FIC_EL_CNT0 + 8'(i), v);
      chk(v, 24'(24'h010101 * (i + 1)));
      h.wr(FIC_EL_FILT0 + 8'(i), 24'(i + 3));
      h.rd(FIC_EL_FILT0 + 8'(i), v);
      chk(v, 24'(i + 3));
    end
    chk(cnt8_q, 24'h040404);
    chk(cnt5_q, 24'h010101);
    h.wr(8'h3F, 24'h5A5A5A);
    h.rd(8'h3F, v);
    chk(v, 24'h000000);
    h.wr(FIC_EL_TB, 24'h000001);
    h.wr(FIC_EL_TB, 24'h000000);
    h.rd(FIC_EL_TB, v);
    chk(v, 24'h000001);
    h.dwr(1'b0, 24'h000000);
    repeat (30) @(posedge mclk);
    h.dwr(1'b0, 24'h000005);
    h.sel(FIC_EL_DIFF);
    chk({16'h0000, idx_q}, 24'h000008);
    for (int k = 0; k < 40 && dat_rdata !== 24'h000005; k++) begin
      @(posedge mclk) #1;
    end
    chk(dat_rdata, 24'h000005);
    #1 h.dual_en = 1'b1;
    h.dwr(1'b0, 24'h000000);
    // input 5 leads input 6: four quadrature steps upward, {B,A} = 01 11 10 00
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk) #1 pin_in[5:4] = 2'(8'h78 >> (6 - 2 * i));
      repeat (3) @(posedge mclk);
    end
    repeat (3) @(posedge mclk);
    #1 chk(cnt5_q, 24'h000004);
    h.rd(FIC_EL_CNT0, v);
    chk(v, 24'h000004);
    h.rd(FIC_EL_CNT0 + 8'h01, v);
    chk(v, 24'h020202);
    end_of_test();
  end
endmodule : tb
`default_nettype wire
